// ===== include/pdg_pkg.sv
// Constants for the power-down and general pin control register bank.
`default_nettype none
package pdg_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] IDX_GLOBAL = 10'h076;
  localparam logic [9:0] IDX_DYNAMIC = 10'h077;
  localparam logic [9:0] IDX_PINS = 10'h078;
  localparam logic [9:0] IDX_CLKGATE = 10'h071;
  // Register width and the mask of writable bits in each register.
  localparam int REG_W = 24;
  localparam logic [23:0] MASK_GLOBAL = 24'h000b7f;
  localparam logic [23:0] MASK_DYNAMIC = 24'h00037f;
  localparam logic [23:0] MASK_PINS = 24'h419fc7;
  localparam logic [23:0] MASK_CLKGATE = 24'h010000;
  // Reset values.
  localparam logic [23:0] RST_GLOBAL = 24'h000000;
  localparam logic [23:0] RST_DYNAMIC = 24'h000000;
  localparam logic [23:0] RST_PINS = 24'h000000;
  localparam logic [23:0] RST_CLKGATE = 24'h000000;
  // Global control fields.
  localparam int POS_ALL_SLEEP = 11;
  localparam int POS_HOST = 9;
  localparam int POS_OSC = 8;
  localparam int POS_ANALOG_HI = 6;
  // Number of power-controlled blocks: host, main osc, then seven analogue.
  localparam int BLOCKS = 9;
  // Pin control fields.
  localparam int POS_PIN3_ON_SDA = 22;
  localparam int POS_PIN2_IBUF = 16;
  localparam int POS_PIN2_OBUF = 15;
  localparam int POS_PIN1_OBUF = 12;
  localparam int POS_PIN2_SEL = 9;
  localparam int POS_PIN1_SEL = 6;
  localparam int POS_PIN3_SEL = 0;
  localparam int SEL_W = 3;
  // Clock gate field.
  localparam int POS_LIGHT_CLK_PINS = 16;
  // Output multiplexer codes.
  localparam logic [2:0] SEL_GROUND = 3'h0;
  localparam logic [2:0] SEL_DOUT0 = 3'h2;
  localparam logic [2:0] SEL_DOUT1 = 3'h3;
  localparam logic [2:0] SEL_SPECIAL = 3'h7;
endpackage
`default_nettype wire

// ===== rtl/pdg_regs.sv
// Power-down and general pin control register bank with an APB slave port.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module pdg_regs (
  // Clock and asynchronous active-low reset.
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal digital sources for the pin multiplexers.
  input wire logic digital_out_0,
  input wire logic digital_out_1,
  input wire logic digital_out_2,
  input wire logic light_enable_channel0,
  input wire logic light_modulation_clock,
  // Output enable wanted by the host port for the secondary data pin.
  input wire logic host_sda_oe,
  // Sleep requests; bit order: host, main osc, then analogue 6 down to 0.
  output logic [8:0] block_sleep,
  // Automatic sleep permissions in the same bit order.
  output logic [8:0] auto_sleep_allowed,
  // Pin 1 and pin 2 drivers.
  output logic pin1_out,
  output logic pin1_oe,
  output logic pin2_out,
  output logic pin2_oe,
  output logic pin2_ibuf_en,
  // Pin 3 multiplexer result.
  output logic pin3_out,
  // Secondary data pin, open drain: out is always low, oe pulls it down.
  output logic sda_sec_out,
  output logic sda_sec_oe
);

  // Stored registers, only writable bits ever hold ones.
  // The clock gate copy holds only the bit that lets the light clock out.
  logic [23:0] global_power_down_control_q;
  logic [23:0] global_power_down_control_d;
  logic [23:0] dynamic_power_down_enables_q;
  logic [23:0] dynamic_power_down_enables_d;
  logic [23:0] general_pin_control_q;
  logic [23:0] general_pin_control_d;
  logic [23:0] clock_pin_gate_q;
  logic [23:0] clock_pin_gate_d;
  // Read data and error answer, prepared during the setup cycle.
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;
  // Decoded index and hit flags.
  // Only one hit flag can be high at a time, since the indices differ.
  logic [9:0] idx;
  logic hit_global;
  logic hit_dynamic;
  logic hit_pins;
  logic hit_clkgate;
  logic mapped;
  logic setup_phase;
  logic write_now;

  // Exemption and automatic-sleep vectors gathered into block order.
  logic [8:0] keep_awake;
  logic [8:0] auto_vec;
  logic all_blocks_sleep;
  // Registered pin levels.
  logic [8:0] sleep_q;
  logic [8:0] sleep_d;
  logic pin1_q;
  logic pin1_d;
  logic pin2_q;
  logic pin2_d;
  logic pin3_q;
  logic pin3_d;
  logic sda_oe_q;
  logic sda_oe_d;
  // Gated light clock for the pin path.
  logic light_clk_gated;

  // Output multiplexer shared by the three pins.
  // Codes that select nothing fall through to a low level, the same as the
  // ground code, so a pin never floats to an unknown or toggling source.
  // Keeping one function for all three pins means a fix lands everywhere.
  function automatic logic pin_mux(
    input logic [2:0] sel,
    input logic d0,
    input logic d1,
    input logic special
  );
    logic r;
    r = 1'b0;
    case (sel)
      pdg_pkg::SEL_DOUT0: r = d0;
      pdg_pkg::SEL_DOUT1: r = d1;
      pdg_pkg::SEL_SPECIAL: r = special;
      pdg_pkg::SEL_GROUND: r = 1'b0;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Address decode; the word index sits above the two byte bits.
  // The two byte bits are ignored, so any byte offset inside a word reaches
  // that word; software is expected to use aligned addresses only.
  assign idx = paddr[11:2];
  assign hit_global = (idx == pdg_pkg::IDX_GLOBAL);
  assign hit_dynamic = (idx == pdg_pkg::IDX_DYNAMIC);
  assign hit_pins = (idx == pdg_pkg::IDX_PINS);
  assign hit_clkgate = (idx == pdg_pkg::IDX_CLKGATE);
  assign mapped = hit_global | hit_dynamic | hit_pins | hit_clkgate;
  assign setup_phase = psel & ~penable;
  // The slave never inserts wait states, so every access phase completes.
  assign write_now = psel & penable & pwrite & ~pslverr_q;

  // Next values of the register file and the bus answer.
  // Masking on the way in keeps reserved bits at zero in the flip-flops,
  // so reads need no second mask and the outputs never see stray ones.
  // An unmapped access leaves every register untouched.
  always_comb begin
    global_power_down_control_d = global_power_down_control_q;
    dynamic_power_down_enables_d = dynamic_power_down_enables_q;
    general_pin_control_d = general_pin_control_q;
    clock_pin_gate_d = clock_pin_gate_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    // Writes land in the access phase; reserved bits are masked off.
    if (write_now) begin
      if (hit_global) begin
        global_power_down_control_d = pwdata[23:0] & pdg_pkg::MASK_GLOBAL;
      end
      if (hit_dynamic) begin
        dynamic_power_down_enables_d = pwdata[23:0] & pdg_pkg::MASK_DYNAMIC;
      end
      if (hit_pins) begin
        general_pin_control_d = pwdata[23:0] & pdg_pkg::MASK_PINS;
      end
      if (hit_clkgate) begin
        clock_pin_gate_d = pwdata[23:0] & pdg_pkg::MASK_CLKGATE;
      end
    end
    // The answer is prepared in the setup cycle and held for the access.
    // Loading it one edge early lets the access phase finish at once, which
    // is why ready can stay high and no wait state is ever needed.
    if (setup_phase) begin
      pslverr_d = ~mapped;
      prdata_d = 32'h00000000;
      if (!pwrite) begin
        // Upper eight bits and reserved fields read as zero.
        if (hit_global) begin
          prdata_d = {8'h00, global_power_down_control_q};
        end else if (hit_dynamic) begin
          prdata_d = {8'h00, dynamic_power_down_enables_q};
        end else if (hit_pins) begin
          prdata_d = {8'h00, general_pin_control_q};
        end else if (hit_clkgate) begin
          prdata_d = {8'h00, clock_pin_gate_q};
        end else begin
          prdata_d = 32'h00000000;
        end
      end
    end
  end

  // Register file flip-flops.
  // Every register returns to zero, which leaves all blocks awake, all
  // automatic sleep disabled and every pin buffer switched off.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      global_power_down_control_q <= pdg_pkg::RST_GLOBAL;
      dynamic_power_down_enables_q <= pdg_pkg::RST_DYNAMIC;
      general_pin_control_q <= pdg_pkg::RST_PINS;
      clock_pin_gate_q <= pdg_pkg::RST_CLKGATE;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      global_power_down_control_q <= global_power_down_control_d;
      dynamic_power_down_enables_q <= dynamic_power_down_enables_d;
      general_pin_control_q <= general_pin_control_d;
      clock_pin_gate_q <= clock_pin_gate_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Bus outputs; ready is constant because no access ever stalls.
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q & psel & penable;

  // Gather the exemption and automatic-sleep bits into block order.
  // Bit 8 is the host port, bit 7 the main oscillator and bits 6 down to 0
  // the analogue blocks, matching the order of the sleep outputs.
  assign all_blocks_sleep = global_power_down_control_q[pdg_pkg::POS_ALL_SLEEP];
  assign keep_awake = {
    global_power_down_control_q[pdg_pkg::POS_HOST],
    global_power_down_control_q[pdg_pkg::POS_OSC],
    global_power_down_control_q[pdg_pkg::POS_ANALOG_HI:0]
  };
  assign auto_vec = {
    dynamic_power_down_enables_q[pdg_pkg::POS_HOST],
    dynamic_power_down_enables_q[pdg_pkg::POS_OSC],
    dynamic_power_down_enables_q[pdg_pkg::POS_ANALOG_HI:0]
  };

  // The decision is registered so that the power switches see a clean
  // level that cannot glitch while the bus is writing the register.
  // Per-block sleep decision: asleep only when global sleep is on and the
  // block is not exempted.
  genvar gi;
  generate
    for (gi = 0; gi < pdg_pkg::BLOCKS; gi++) begin : g_block
      assign sleep_d[gi] = all_blocks_sleep & ~keep_awake[gi];
    end
  endgenerate

  // The light clock only reaches the pin path when gated on.
  // Without the gate bit the clock would toggle pin 1 whenever its select
  // code picks it, wasting power in systems that never use it.
  assign light_clk_gated = light_modulation_clock &
    clock_pin_gate_q[pdg_pkg::POS_LIGHT_CLK_PINS];

  // Next values of the pin levels.
  // All three pins pass through one flip-flop each, so every pin level is
  // one clock behind its source and free of decode glitches.
  always_comb begin
    pin1_d = pin_mux(general_pin_control_q[pdg_pkg::POS_PIN1_SEL +: pdg_pkg::SEL_W],
      digital_out_0, digital_out_1, light_clk_gated);
    pin2_d = pin_mux(general_pin_control_q[pdg_pkg::POS_PIN2_SEL +: pdg_pkg::SEL_W],
      digital_out_0, digital_out_1, light_enable_channel0);
    pin3_d = pin_mux(general_pin_control_q[pdg_pkg::POS_PIN3_SEL +: pdg_pkg::SEL_W],
      digital_out_0, digital_out_1, digital_out_2);
    // When routed, a high pin 3 level pulls the line low; a pull-up
    // outside restores it, which saves power while pin 3 idles low.
    if (general_pin_control_q[pdg_pkg::POS_PIN3_ON_SDA]) begin
      sda_oe_d = pin3_d;
    end else begin
      sda_oe_d = host_sda_oe;
    end
  end

  // Pin level flip-flops.
  // Reset holds every pin low and releases the secondary data line, so the
  // host port owns that line until software routes pin 3 onto it.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_q <= 9'h000;
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
      pin3_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
      pin1_q <= pin1_d;
      pin2_q <= pin2_d;
      pin3_q <= pin3_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // Power control outputs.
  // The automatic sleep permissions are plain register bits; the logic that
  // acts on them sits in each block.
  assign block_sleep = sleep_q;
  assign auto_sleep_allowed = auto_vec;

  // Pin driver outputs and buffer enables.
  // The buffer enables come straight from their bits, so they change one
  // clock before the pin levels that follow a select change.
  assign pin1_out = pin1_q;
  assign pin1_oe = general_pin_control_q[pdg_pkg::POS_PIN1_OBUF];
  assign pin2_out = pin2_q;
  assign pin2_oe = general_pin_control_q[pdg_pkg::POS_PIN2_OBUF];
  assign pin2_ibuf_en = general_pin_control_q[pdg_pkg::POS_PIN2_IBUF];
  assign pin3_out = pin3_q;
  // Open drain: the driven level is always low.
  assign sda_sec_out = 1'b0;
  assign sda_sec_oe = sda_oe_q;

endmodule
`default_nettype wire

// ===== verif/pdg_regs_chk.sv
// Checker bound to the power-down and general pin control bank.
`timescale 1ns/1ns
`default_nettype none
module pdg_regs_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [8:0] block_sleep,
  input wire logic [8:0] auto_sleep_allowed,
  input wire logic pin1_oe,
  input wire logic sda_sec_out
);
  // Access phase, writes, the word index and the readable bits of that word.
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic [9:0] idx = paddr[11:2];
  wire logic gw = wr && idx == pdg_pkg::IDX_GLOBAL;
  wire logic gsl = pwdata[11];
  wire logic ob1 = pwdata[12];
  wire logic [8:0] wd9 = {pwdata[9:8], pwdata[6:0]};
  wire logic [23:0] rmask = idx == pdg_pkg::IDX_GLOBAL ? pdg_pkg::MASK_GLOBAL :
    idx == pdg_pkg::IDX_DYNAMIC ? pdg_pkg::MASK_DYNAMIC : idx == pdg_pkg::IDX_PINS ?
    pdg_pkg::MASK_PINS : idx == pdg_pkg::IDX_CLKGATE ? pdg_pkg::MASK_CLKGATE : 24'h0;
  // All checks run on the bus clock and rest while reset is low.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_err_unmapped: assert property (acc |-> pslverr == !(|rmask))
    else $error("error flag wrong for address");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("error flag outside access");
  a_resv_zero: assert property (acc && !pwrite |-> (prdata & ~{8'h00, rmask}) == 32'h0)
    else $error("reserved bits read nonzero");
  a_auto_follow: assert property (wr && idx == pdg_pkg::IDX_DYNAMIC |=> auto_sleep_allowed == $past(wd9))
    else $error("auto sleep mismatch");
  a_sleep_follow: assert property (gw |=> ##1 block_sleep == ($past(gsl, 2) ? ~$past(wd9, 2) : 9'h000))
    else $error("sleep requests mismatch");
  a_sleep_hold: assert property (!$past(gw, 2) && $past(rst_b, 2) |-> $stable(block_sleep))
    else $error("sleep changed without write");
  a_pin1_buffer: assert property (wr && idx == pdg_pkg::IDX_PINS |=> pin1_oe == $past(ob1))
    else $error("pin 1 buffer mismatch");
  a_sda_low: assert property (sda_sec_out == 1'b0)
    else $error("secondary data driven high");
  c_sleep: cover property (gw && gsl);
  c_unmapped: cover property (acc && !(|rmask));
  c_route: cover property (wr && idx == pdg_pkg::IDX_PINS && pwdata[22]);
endmodule
bind pdg_regs pdg_regs_chk u_pdg_regs_chk (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .pin1_oe(pin1_oe),
  .block_sleep(block_sleep), .auto_sleep_allowed(auto_sleep_allowed), .sda_sec_out(sda_sec_out)
);
`default_nettype wire

// ===== verif/pdg_regs_tb.sv
// Self-checking bench for the power-down and general pin control bank.
`timescale 1ns/1ns
`default_nettype none
module pdg_regs_tb;
  logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  // Sources: host pull, light clock, light enable, out2, out1, out0.
  logic [5:0] src = 6'h00;
  logic pready, pslverr, err, pin1_out, pin1_oe, pin2_out, pin2_oe, pin2_ibuf_en;
  logic pin3_out, sda_sec_out, sda_sec_oe;
  logic [8:0] block_sleep, auto_sleep_allowed;
  int miscompares = 0, cmp_count = 0;
  logic [11:0] adr [4] = '{{pdg_pkg::IDX_GLOBAL, 2'b00}, {pdg_pkg::IDX_DYNAMIC, 2'b00},
    {pdg_pkg::IDX_PINS, 2'b00}, {pdg_pkg::IDX_CLKGATE, 2'b00}};
  pdg_regs u_pdg_regs (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .digital_out_0(src[0]), .digital_out_1(src[1]), .digital_out_2(src[2]),
    .light_enable_channel0(src[3]), .light_modulation_clock(src[4]), .host_sda_oe(src[5]),
    .block_sleep(block_sleep), .auto_sleep_allowed(auto_sleep_allowed), .pin1_out(pin1_out),
    .pin1_oe(pin1_oe), .pin2_out(pin2_out), .pin2_oe(pin2_oe), .pin2_ibuf_en(pin2_ibuf_en),
    .pin3_out(pin3_out), .sda_sec_out(sda_sec_out), .sda_sec_oe(sda_sec_oe)
  );
  // The 250 MHz clock.
  initial forever #2 mclk = ~mclk;
  // Counts a comparison and reports a mismatch at once.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Waits for ready however long it takes; only the watchdog ends a hang.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Writes a word, reads it back and expects only the writable bits.
  task wrrd(input logic [11:0] a, input logic [23:0] v, input logic [23:0] m);
    apb(1'b1, a, 32'(v));
    apb(1'b0, a, 32'h0);
    chk(rd, 32'(v & m));
  endtask
  // Expected multiplexer output; unlisted codes give a low level.
  function automatic logic pick(input logic [2:0] c, input logic a, b, s);
    return c == 3'h2 ? a : c == 3'h3 ? b : c == 3'h7 ? s : 1'b0;
  endfunction
  // After reset every register and derived output reads zero.
  task t_reset_vals;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, adr[i], 32'h0);
      chk(rd, 32'h0);
    end
    #1;
    chk(32'({block_sleep, auto_sleep_allowed, pin1_oe, pin2_oe}), 32'h0);
    chk(32'({pin1_out, pin2_out, pin3_out, pin2_ibuf_en}), 32'h0);
    chk(32'({sda_sec_out, sda_sec_oe, pready, err}), 32'h2);
  endtask
  // Global sleep with mixes of exemptions, ending with everything asleep.
  task automatic t_global;
    logic [23:0] v [5] = '{24'hffffff, 24'h000b00, 24'h000855, 24'h000400, 24'h000800};
    for (int i = 0; i < 5; i++) begin
      wrrd(adr[0], v[i], pdg_pkg::MASK_GLOBAL);
      #1;
      chk(32'(block_sleep), 32'(v[i][11] ? 9'(~{v[i][9:8], v[i][6:0]}) : 9'h000));
      chk(32'(err), 32'h0);
    end
  endtask
  // Automatic sleep permissions and pin buffer enables follow their bits.
  task automatic t_enables;
    logic [23:0] v [3] = '{24'hffffff, 24'h000155, 24'h009000};
    logic [23:0] w;
    for (int i = 0; i < 3; i++) begin
      w = v[i] ^ 24'h011000;
      wrrd(adr[1], v[i], pdg_pkg::MASK_DYNAMIC);
      wrrd(adr[2], w, pdg_pkg::MASK_PINS);
      #1;
      chk(32'(auto_sleep_allowed), 32'({v[i][9:8], v[i][6:0]}));
      chk(32'({pin2_ibuf_en, pin2_oe, pin1_oe}), 32'({w[16], w[15], w[12]}));
    end
  endtask
  // Every select code on all pins, routed and not, with two source sets.
  task t_mux(input logic gate);
    logic [5:0] s;
    logic [2:0] c;
    logic e3;
    for (int k = 0; k < 32; k++) begin
      s = k[0] ? 6'h12 : 6'h2d;
      c = k[3:1];
      @(posedge mclk);
      src <= s;
      wrrd(adr[2], {1'b0, k[4], 10'h0, c, c, 3'h0, c}, pdg_pkg::MASK_PINS);
      #1;
      e3 = pick(c, s[0], s[1], s[2]);
      chk(32'(pin1_out), 32'(pick(c, s[0], s[1], gate & s[4])));
      chk(32'(pin2_out), 32'(pick(c, s[0], s[1], s[3])));
      chk(32'(pin3_out), 32'(e3));
      chk(32'({sda_sec_out, sda_sec_oe}), 32'({1'b0, k[4] ? e3 : s[5]}));
    end
  endtask
  // An unmapped word flags an error, keeps no data and reads zero.
  task t_unmapped;
    apb(1'b1, 12'h1e4, 32'hffffffff);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h1e4, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
  endtask
  // Prints the counts and the verdict, then stops.
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Cuts a hang short; the run needs well under 20 us.
  initial begin
    #100000;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test;
  end
  // Main sequence, with a second reset in mid-run.
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset_vals;
    t_global;
    t_enables;
    t_mux(1'b0);
    wrrd(adr[3], 24'hffffff, pdg_pkg::MASK_CLKGATE);
    t_mux(1'b1);
    t_unmapped;
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset_vals;
    end_of_test;
  end
endmodule
`default_nettype wire
